// File: design/fdrs_top.sv
// FSK receive setup: AXI4-Lite config registers plus demod selection,
// multi-level slicing and Viterbi-path latency for the received symbols.
// Assumes samples arrive from logic on the same clock as the bus.
//
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module fdrs_top
    import fdrs_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                reset_n,
    input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [AXI_AW-1:0]   s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic                sample_valid,
    input  wire logic [SAMPLE_W-1:0] corr_sample,
    input  wire logic [SAMPLE_W-1:0] lin_sample,
    input  wire logic [SAMPLE_W-1:0] env_level,
    output logic [9:0]               correlator_bandwidth,
    output logic [9:0]               lowpass_cutoff_code,
    output logic                     coef_odd,
    output logic [1:0]               coef_parity,
    output logic [1:0]               symbol_out,
    output logic                     symbol_valid
);
    // ==========================================================
    // Register bus state
    logic [AXI_AW-1:0] awaddr_reg, awaddr_next;
    logic              aw_got_reg, aw_got_next;
    logic [31:0]       wdata_reg, wdata_next;
    logic [3:0]        wstrb_reg, wstrb_next;
    logic              w_got_reg, w_got_next;
    logic              bvalid_reg, bvalid_next;
    logic [1:0]        bresp_reg, bresp_next;
    logic              rvalid_reg, rvalid_next;
    logic [1:0]        rresp_reg, rresp_next;
    logic [31:0]       rdata_reg, rdata_next;
    logic [31:0]       demod_reg, demod_next;
    logic [31:0]       detect_reg, detect_next;
    logic              wr_do;
    fdrs_demod_cfg_t   dcfg;
    fdrs_detect_cfg_t  tcfg;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb,
                                          input logic [31:0] mask);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r & mask;
    endfunction : merge

    assign dcfg          = fdrs_demod_cfg_t'(demod_reg);
    assign tcfg          = fdrs_detect_cfg_t'(detect_reg);
    assign s_axi_awready = !aw_got_reg && !bvalid_reg;
    assign s_axi_wready  = !w_got_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;
    assign wr_do         = aw_got_reg && w_got_reg && !bvalid_reg;

    // ==========================================================
    // Datapath state
    logic [1:0]        dly_mem [DLY_DEPTH];
    logic [DLY_AW-1:0] wr_ptr_reg, wr_ptr_next;
    logic [1:0]        sym_reg, sym_next;
    logic              sval_reg, sval_next;
    logic [DLY_AW-1:0] rd_idx;
    logic [6:0]        latency;
    logic [1:0]        sym_now;
    logic              mode_ok;
    logic              use_vit;
    logic signed [SAMPLE_W-1:0] thr_s;
    logic signed [SAMPLE_W-1:0] corr_s;

    // ==========================================================
    // Register bus next state
    always_comb begin
        awaddr_next = awaddr_reg;
        aw_got_next = aw_got_reg;
        wdata_next  = wdata_reg;
        wstrb_next  = wstrb_reg;
        w_got_next  = w_got_reg;
        bvalid_next = bvalid_reg;
        bresp_next  = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next  = rresp_reg;
        rdata_next  = rdata_reg;
        demod_next  = demod_reg;
        detect_next = detect_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            awaddr_next = s_axi_awaddr;
            aw_got_next = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
            w_got_next = 1'b1;
        end
        if (wr_do) begin
            aw_got_next = 1'b0;
            w_got_next  = 1'b0;
            bvalid_next = 1'b1;
            bresp_next  = RESP_OKAY;
            unique case ({awaddr_reg[AXI_AW-1:2], 2'b00})
                DEMOD_CFG_OFS:  demod_next  = merge(demod_reg, wdata_reg, wstrb_reg, DEMOD_MASK);
                DETECT_CFG_OFS: detect_next = merge(detect_reg, wdata_reg, wstrb_reg, DETECT_MASK);
                STATUS_OFS:     bresp_next  = RESP_OKAY;
                default:        bresp_next  = RESP_SLVERR;
            endcase
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            unique case ({s_axi_araddr[AXI_AW-1:2], 2'b00})
                DEMOD_CFG_OFS:  rdata_next = demod_reg;
                DETECT_CFG_OFS: rdata_next = detect_reg;
                // Live view of the decision path
                STATUS_OFS:     rdata_next = {19'h00000, latency, use_vit, dcfg.demod_select, sym_reg};
                default: begin
                    rdata_next = 32'h0000_0000;
                    rresp_next = RESP_SLVERR;
                end
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            awaddr_reg <= '0;
            aw_got_reg <= 1'b0;
            wdata_reg  <= 32'h0000_0000;
            wstrb_reg  <= 4'h0;
            w_got_reg  <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg  <= RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
            demod_reg  <= DEMOD_RST;
            detect_reg <= DETECT_RST;
        end else begin
            awaddr_reg <= awaddr_next;
            aw_got_reg <= aw_got_next;
            wdata_reg  <= wdata_next;
            wstrb_reg  <= wstrb_next;
            w_got_reg  <= w_got_next;
            bvalid_reg <= bvalid_next;
            bresp_reg  <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg  <= rresp_next;
            rdata_reg  <= rdata_next;
            demod_reg  <= demod_next;
            detect_reg <= detect_next;
        end
    end

    assign correlator_bandwidth = dcfg.correlator_bandwidth;
    assign lowpass_cutoff_code  = dcfg.lowpass_cutoff_code;
    assign coef_odd             = dcfg.coef_odd;
    assign coef_parity          = dcfg.coef_parity;
    assign symbol_out           = sym_reg;
    assign symbol_valid         = sval_reg;

    // ==========================================================
    // Decision path
    assign thr_s  = signed'({5'h00, tcfg.multilevel_threshold});
    assign corr_s = signed'(corr_sample);

    always_comb begin
        unique case (tcfg.path_mem)
            2'h0: latency = 7'(PM_LEN0 << 1);
            2'h1: latency = 7'(PM_LEN1 << 1);
            2'h2: latency = 7'(PM_LEN2 << 1);
            2'h3: latency = 7'(PM_LEN3 << 1);
        endcase
    end

    // delay of twice the path memory; full depth wraps onto wr_ptr
    assign rd_idx = wr_ptr_reg - latency[DLY_AW-1:0];
    // Viterbi only meaningful on the 3FSK path
    assign use_vit = tcfg.viterbi_en && (dcfg.demod_select == SEL_CORR3);

    always_comb begin
        mode_ok = 1'b1;
        sym_now = SYM_L0;
        unique case (dcfg.demod_select)
            // linear path sliced against the envelope
            SEL_LINEAR: sym_now = {1'b0, signed'(lin_sample) > signed'(env_level)};
            // correlator output centred on zero, no baseline tracking
            SEL_CORR2:  sym_now = {1'b0, !corr_s[SAMPLE_W-1]};
            // symmetric thresholds, same field for both detectors
            SEL_CORR3: begin
                if (corr_s > thr_s) begin
                    sym_now = SYM_L2;
                end else if (corr_s < -thr_s) begin
                    sym_now = SYM_L0;
                end else begin
                    sym_now = SYM_L1;
                end
            end
            // outer pair programmable, middle fixed at zero
            SEL_CORR4: begin
                if (corr_s > thr_s) begin
                    sym_now = SYM_L3;
                end else if (!corr_s[SAMPLE_W-1]) begin
                    sym_now = SYM_L2;
                end else if (corr_s >= -thr_s) begin
                    sym_now = SYM_L1;
                end else begin
                    sym_now = SYM_L0;
                end
            end
            // Undefined selections emit nothing
            default: mode_ok = 1'b0;
        endcase
    end

    always_comb begin
        wr_ptr_next = wr_ptr_reg;
        sym_next    = sym_reg;
        sval_next   = sample_valid && mode_ok;
        if (sample_valid && mode_ok) begin
            wr_ptr_next = wr_ptr_reg + 1'b1;
            sym_next    = use_vit ? dly_mem[rd_idx] : sym_now;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_reg <= '0;
            sym_reg    <= SYM_L0;
            sval_reg   <= 1'b0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            sym_reg    <= sym_next;
            sval_reg   <= sval_next;
        end
    end

    // History is data only, so it needs no reset
    always_ff @(posedge clk) begin
        if (sample_valid && mode_ok) begin
            dly_mem[wr_ptr_reg] <= sym_now;
        end
    end

    // ==========================================================
    // Checks
    lin_route_a: assert property (@(posedge clk) disable iff (!reset_n)
        sample_valid && dcfg.demod_select == SEL_LINEAR && $stable(demod_reg)
        |=> symbol_valid && symbol_out == {1'b0, $past(signed'(lin_sample) > signed'(env_level))})
        else $error("linear path decision wrong");
    corr_two_a: assert property (@(posedge clk) disable iff (!reset_n)
        sample_valid && dcfg.demod_select == SEL_CORR2
        |=> symbol_valid && symbol_out == {1'b0, !$past(corr_sample[SAMPLE_W-1])})
        else $error("2FSK correlator decision wrong");
    corr_three_a: assert property (@(posedge clk) disable iff (!reset_n)
        sample_valid && dcfg.demod_select == SEL_CORR3 && !tcfg.viterbi_en && corr_s > thr_s
        |=> symbol_out == SYM_L2)
        else $error("3FSK threshold decision wrong");
    four_low_a: assert property (@(posedge clk) disable iff (!reset_n)
        sample_valid && dcfg.demod_select == SEL_CORR4 && corr_s < -thr_s
        |=> symbol_out == SYM_L0)
        else $error("4FSK lower threshold wrong");
    four_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        sample_valid && dcfg.demod_select == SEL_CORR4
        |=> symbol_out[1] == !$past(corr_sample[SAMPLE_W-1]))
        else $error("4FSK zero threshold wrong");
    vit_depth_a: assert property (@(posedge clk) disable iff (!reset_n)
        tcfg.path_mem == 2'h3 |-> rd_idx == wr_ptr_reg && latency == 7'h40)
        else $error("Viterbi latency not twice memory");
    bad_mode_a: assert property (@(posedge clk) disable iff (!reset_n)
        dcfg.demod_select[2] |=> !symbol_valid)
        else $error("undefined selection produced output");
    cfg_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        !wr_do |=> $stable(demod_reg) && $stable(detect_reg))
        else $error("config changed without host write");
    bresp_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rd_answer_a: assert property (@(posedge clk) disable iff (!reset_n)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 s_axi_rvalid [*1])
        else $error("read not answered next cycle");
endmodule : fdrs_top

// File: design/fdrs_pkg.sv
// Constants, field layouts and carriers for the FSK receive setup block.
// Assumes one 50 MHz clock shared with the demodulator datapath.
package fdrs_pkg;
    // ==========================================================
    // Bus and register map
    localparam int          AXI_AW         = 12;
    localparam logic [11:0] DEMOD_CFG_OFS  = 12'h000;
    localparam logic [11:0] DETECT_CFG_OFS = 12'h004;
    localparam logic [11:0] STATUS_OFS     = 12'h008;
    localparam logic [31:0] DEMOD_MASK     = 32'h3FFF_FFF0;
    localparam logic [31:0] DETECT_MASK    = 32'h0000_6FF0;
    localparam logic [31:0] DEMOD_RST      = 32'h0000_0000;
    localparam logic [31:0] DETECT_RST     = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
    // ==========================================================
    // Demodulator selection codes
    localparam logic [2:0]  SEL_LINEAR     = 3'h0;
    localparam logic [2:0]  SEL_CORR2      = 3'h1;
    localparam logic [2:0]  SEL_CORR3      = 3'h2;
    localparam logic [2:0]  SEL_CORR4      = 3'h3;
    // ==========================================================
    // Datapath
    localparam int          SAMPLE_W       = 12;
    localparam int          DLY_AW         = 6;
    localparam int          DLY_DEPTH      = 64;
    localparam logic [6:0]  PM_LEN0        = 7'h04;
    localparam logic [6:0]  PM_LEN1        = 7'h06;
    localparam logic [6:0]  PM_LEN2        = 7'h08;
    localparam logic [6:0]  PM_LEN3        = 7'h20;
    // Symbol codes: lowest level is 0, rising with frequency
    localparam logic [1:0]  SYM_L0         = 2'h0;
    localparam logic [1:0]  SYM_L1         = 2'h1;
    localparam logic [1:0]  SYM_L2         = 2'h2;
    localparam logic [1:0]  SYM_L3         = 2'h3;
    // ==========================================================
    // Register layouts
    typedef struct packed {
        logic [1:0] rsv_hi;
        logic [9:0] lowpass_cutoff_code;
        logic [9:0] correlator_bandwidth;
        logic [1:0] coef_parity;
        logic       coef_odd;
        logic [2:0] demod_select;
        logic [3:0] rsv_lo;
    } fdrs_demod_cfg_t;
    typedef struct packed {
        logic [16:0] rsv_hi;
        logic [1:0]  path_mem;
        logic        rsv_12;
        logic        viterbi_en;
        logic [6:0]  multilevel_threshold;
        logic [3:0]  rsv_lo;
    } fdrs_detect_cfg_t;
endpackage : fdrs_pkg

// File: bench/fdrs_host_model.sv
// Host side: AXI4-Lite master tasks and the demodulator field arithmetic.
// Assumes it shares the bench clock and that the slave is out of reset.
`timescale 1ns/1ps
module fdrs_host_model
    import fdrs_pkg::*;
#(
    parameter int DEMODULATOR_CLOCK_HZ = 4000000
)(
    input  wire logic              clk,
    output logic [AXI_AW-1:0]      awaddr,
    output logic                   awvalid,
    input  wire logic              awready,
    output logic [31:0]            wdata,
    output logic [3:0]             wstrb,
    output logic                   wvalid,
    input  wire logic              wready,
    input  wire logic [1:0]        bresp,
    input  wire logic              bvalid,
    output logic                   bready,
    output logic [AXI_AW-1:0]      araddr,
    output logic                   arvalid,
    input  wire logic              arready,
    input  wire logic [31:0]       rdata,
    input  wire logic [1:0]        rresp,
    input  wire logic              rvalid,
    output logic                   rready
);
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, wdata, wstrb, araddr} = '0;
    end

    // ==========================================================
    // Bus cycles; each wait is bounded, ok stays low on a hang
    task automatic axi_write(input logic [AXI_AW-1:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] resp, output logic ok);
        ok = 1'b0;
        resp = 2'h3;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (int i = 0; i < 64 && !ok; i++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                ok = 1'b1;
            end
        end
    endtask : axi_write

    task automatic axi_read(input logic [AXI_AW-1:0] a, output logic [31:0] d,
                            output logic [1:0] resp, output logic ok);
        ok = 1'b0;
        resp = 2'h3;
        d = '0;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (int i = 0; i < 64 && !ok; i++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                resp = rresp;
                rready <= 1'b0;
                ok = 1'b1;
            end
        end
    endtask : axi_read

    // ==========================================================
    // slicer threshold from K, rounded; dev is the inner deviation
    function automatic int thr_code(input logic [2:0] sel, input int dev, input int outer);
        int k;
        int d;
        int pick;
        k = (100000 + dev) / (2 * dev);
        pick = 32;
        if (sel == SEL_CORR4) begin
            k = (100000 + 2 * dev) / (4 * dev);
            // snap to the allowed 4FSK set
            for (int c = 3; c <= 32; c++) begin
                d = c % 4;
                if ((d == 0 || d == 3) && (k - c) * (k - c) < (k - pick) * (k - pick)) pick = c;
            end
            return (78 * outer * pick + 50000) / 100000;
        end
        return (57 * dev * k + 50000) / 100000;
    endfunction : thr_code

    // field arithmetic, 2FSK and 3FSK only
    // rate is the symbol rate; recovery clock is kept at 32 times it
    function automatic logic [31:0] demod_word(input logic [2:0] sel, input int dev, input int rate);
        int          k;
        int          h;
        real         fc;
        logic [31:0] w;
        k = (sel == SEL_CORR3) ? (100000 + dev) / (2 * dev) : (100000 + dev / 2) / dev;
        h = (k % 2 == 0) ? k / 2 : (k + 1) / 2;
        fc = (sel == SEL_CORR3) ? 1.0 * rate : 0.75 * rate;
        w = '0;
        w[6:4] = sel;
        w[7] = k[0];
        w[9:8] = (h % 2 == 1) ? 2'h2 : 2'h0;
        w[19:10] = 10'(DEMODULATOR_CLOCK_HZ * k / 400000);
        w[29:20] = 10'(int'($ceil(2048.0 * 3.14159265 * fc / DEMODULATOR_CLOCK_HZ)));
        return w;
    endfunction : demod_word
endmodule : fdrs_host_model

// File: bench/tb_fsk_demod_receive_setup.sv
// Self-checking bench for the FSK receive setup block.
// Assumes the host model drives the register bus; the bench drives samples.
`timescale 1ns/1ps
module tb_fsk_demod_receive_setup;
    import fdrs_pkg::*;
    logic                clk;
    logic                reset_n;
    logic                sample_valid;
    logic [SAMPLE_W-1:0] corr_sample;
    logic [SAMPLE_W-1:0] lin_sample;
    logic [SAMPLE_W-1:0] env_level;
    logic [AXI_AW-1:0]   awaddr;
    logic [AXI_AW-1:0]   araddr;
    logic [31:0]         wdata;
    logic [31:0]         rdata;
    logic [3:0]          wstrb;
    logic [1:0]          bresp;
    logic [1:0]          rresp;
    logic                awvalid, awready, wvalid, wready, bvalid, bready;
    logic                arvalid, arready, rvalid, rready;
    logic [9:0]          correlator_bandwidth;
    logic [9:0]          lowpass_cutoff_code;
    logic                coef_odd;
    logic [1:0]          coef_parity;
    logic [1:0]          symbol_out;
    logic                symbol_valid;
    int                  mismatches = 0;
    int                  tests_run = 0;

    fdrs_host_model host_u (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    fdrs_top dut_u (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sample_valid(sample_valid), .corr_sample(corr_sample), .lin_sample(lin_sample),
        .env_level(env_level), .correlator_bandwidth(correlator_bandwidth),
        .lowpass_cutoff_code(lowpass_cutoff_code), .coef_odd(coef_odd), .coef_parity(coef_parity),
        .symbol_out(symbol_out), .symbol_valid(symbol_valid));

    initial clk = 1'b0;
    always #10 clk = ~clk;

    // ==========================================================
    // Shared helpers
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic hang(input logic ok);
        if (ok !== 1'b1) begin
            mismatches++;
            $display("Error at %0t: bus answer never came", $time);
            summarize();
        end
    endtask : hang

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        logic [1:0] r;
        logic       ok;
        host_u.axi_write(a, d, s, r, ok);
        hang(ok);
        check(32'(r), 32'(er));
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        logic        ok;
        host_u.axi_read(a, d, r, ok);
        hang(ok);
        check(32'(r), 32'(er));
        check(d & m, exp);
    endtask : rd

    // One sample in, decision sampled after the answering edge
    task automatic smp(input int c, input int l, input int e, output logic v, output logic [1:0] s);
        @(posedge clk);
        sample_valid <= 1'b1;
        corr_sample  <= SAMPLE_W'(c);
        lin_sample   <= SAMPLE_W'(l);
        env_level    <= SAMPLE_W'(e);
        @(posedge clk);
        sample_valid <= 1'b0;
        #1;
        v = symbol_valid;
        s = symbol_out;
    endtask : smp

    // ==========================================================
    // Scenarios
    task automatic test_regs();
        logic [31:0] w;
        w = host_u.demod_word(SEL_CORR2, 2000, 4800);
        rd(DEMOD_CFG_OFS, DEMOD_RST, 32'hFFFF_FFFF, RESP_OKAY);
        rd(DETECT_CFG_OFS, DETECT_RST, 32'hFFFF_FFFF, RESP_OKAY);
        wr(DEMOD_CFG_OFS, w | 32'hC000_000F, 4'hF, RESP_OKAY);
        rd(DEMOD_CFG_OFS, w, 32'hFFFF_FFFF, RESP_OKAY);
        wr(STATUS_OFS, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
        rd(DEMOD_CFG_OFS, w, 32'hFFFF_FFFF, RESP_OKAY);
        check(32'(correlator_bandwidth), 32'h0000_01F4);
        check(32'(lowpass_cutoff_code), 32'h0000_0006);
        check(32'({coef_parity, coef_odd}), 32'h0000_0004);
        wr(DETECT_CFG_OFS, 32'hFFFF_FFFF, 4'h1, RESP_OKAY);
        rd(DETECT_CFG_OFS, 32'h0000_00F0, 32'hFFFF_FFFF, RESP_OKAY);
        wr(12'h00C, 32'h0000_0001, 4'hF, RESP_SLVERR);
        rd(12'h00C, 32'h0000_0000, 32'hFFFF_FFFF, RESP_SLVERR);
        $display("test_regs done");
    endtask : test_regs

    // exp[2] is the expected valid, exp[1:0] the symbol
    task automatic mode(input logic [2:0] sel, input int c, input int l, input int e, input logic [2:0] exp);
        logic       v;
        logic [1:0] s;
        wr(DEMOD_CFG_OFS, 32'(sel) << 4, 4'hF, RESP_OKAY);
        smp(c, l, e, v, s);
        check(32'(v), 32'(exp[2]));
        if (exp[2]) check(32'(s), 32'(exp[1:0]));
    endtask : mode

    task automatic test_modes();
        int t3;
        int t4;
        t3 = host_u.thr_code(SEL_CORR3, 2000, 0);
        t4 = host_u.thr_code(SEL_CORR4, 1000, 3000);
        wr(DETECT_CFG_OFS, 32'(t3) << 4, 4'hF, RESP_OKAY);
        mode(SEL_LINEAR, -50, 10, 5, 3'h5);
        mode(SEL_LINEAR, 50, -3, 5, 3'h4);
        mode(SEL_CORR2, 0, -9, 9, 3'h5);
        mode(SEL_CORR2, -1, 9, -9, 3'h4);
        mode(SEL_CORR3, t3 + 1, 0, 0, 3'h6);
        mode(SEL_CORR3, t3, 0, 0, 3'h5);
        mode(SEL_CORR3, -t3, 0, 0, 3'h5);
        mode(SEL_CORR3, -t3 - 1, 0, 0, 3'h4);
        wr(DETECT_CFG_OFS, 32'(t4) << 4, 4'hF, RESP_OKAY);
        mode(SEL_CORR4, t4 + 1, 0, 0, 3'h7);
        mode(SEL_CORR4, 0, 0, 0, 3'h6);
        mode(SEL_CORR4, -1, 0, 0, 3'h5);
        mode(SEL_CORR4, -t4 - 1, 0, 0, 3'h4);
        mode(3'h4, 50, 0, 0, 3'h0);
        $display("test_modes done");
    endtask : test_modes

    // Long equal runs through each path memory; output trails by twice the length
    task automatic test_viterbi();
        int         len [4] = '{8, 12, 16, 64};
        logic       v;
        logic [1:0] s;
        wr(DEMOD_CFG_OFS, 32'(SEL_CORR3) << 4, 4'hF, RESP_OKAY);
        // runs hold no zero symbols, so every path memory is long enough
        for (int p = 0; p < 4; p++) begin
            wr(DETECT_CFG_OFS, 32'h0000_0940 | (32'(p) << 13), 4'hF, RESP_OKAY);
            rd(STATUS_OFS, (32'(len[p]) << 6) | 32'h0000_0020, 32'h0000_1FE0, RESP_OKAY);
            for (int i = 0; i <= 2 * len[p]; i++) begin
                smp(i < len[p] ? 50 : -50, 0, 0, v, s);
                check(32'(v), 32'h0000_0001);
                if (i == 2 * len[p] - 1) check(32'(s), 32'(SYM_L2));
                if (i == 2 * len[p]) check(32'(s), 32'(SYM_L0));
            end
        end
        $display("test_viterbi done");
    endtask : test_viterbi

    // 2FSK alternating preamble then a long run; 3FSK preamble of ones
    task automatic test_preamble();
        logic       v;
        logic [1:0] s;
        int         t3;
        t3 = host_u.thr_code(SEL_CORR3, 2000, 0);
        wr(DEMOD_CFG_OFS, 32'(SEL_CORR2) << 4, 4'hF, RESP_OKAY);
        // alternating bits, then twelve equal bits
        for (int i = 0; i < 28; i++) begin
            smp((i < 16 && i[0]) ? -40 : 40, 0, 0, v, s);
            check(32'({v, s}), (i < 16 && i[0]) ? 32'h0000_0004 : 32'h0000_0005);
        end
        wr(DETECT_CFG_OFS, 32'(t3) << 4, 4'hF, RESP_OKAY);
        wr(DEMOD_CFG_OFS, 32'(SEL_CORR3) << 4, 4'hF, RESP_OKAY);
        // forty ones swing between the outer levels
        for (int i = 0; i < 40; i++) begin
            smp(i[0] ? -t3 - 1 : t3 + 1, 0, 0, v, s);
            check(32'({v, s}), i[0] ? 32'h0000_0004 : 32'h0000_0006);
        end
        $display("test_preamble done");
    endtask : test_preamble

    initial begin
        reset_n = 1'b0;
        sample_valid = 1'b0;
        {corr_sample, lin_sample, env_level} = '0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        test_regs();
        test_modes();
        test_viterbi();
        test_preamble();
        summarize();
    end
endmodule : tb_fsk_demod_receive_setup
